// ### rea_defs.vh
`ifndef REA_DEFS_VH
`define REA_DEFS_VH

// ==========================================================
// Register map (word index on the register port)
`define REA_ADDR_W 8
`define REA_A_OFS_BASE 8'h00
`define REA_A_THR 8'h06
`define REA_A_MEASUREMENT_MODE_REGISTER 8'h07
`define REA_A_LCYC 8'h08
`define REA_A_ACCMODE 8'h09
`define REA_A_INTERRUPT_MASK_ZERO 8'h0a
`define REA_A_INTERRUPT_STATUS_ZERO 8'h0b
`define REA_A_PHASE_SIGN_REGISTER 8'h0c
`define REA_A_NRG_BASE 8'h10

// ==========================================================
// Field positions
`define REA_B_SIGN_SEL 1
`define REA_B_CLR_ON_RD 6
`define REA_B_CONNECTION_SELECT_LO 4
`define REA_B_HF_TOT 2
`define REA_B_HF_FUND 3
`define REA_B_REV_A 10
`define REA_B_VSIGN_A 4

// ==========================================================
// Reset values
`define REA_THR_RST 8'h03

// ==========================================================
// Timing: accumulation tick from the core clock, both in kHz
`define REA_CLK_KHZ 16'h4e20
`define REA_TICK_KHZ 16'h0400

`endif

// ### rea_reactive_energy.v
`include "rea_defs.vh"

module rea_reactive_energy #(
  parameter DW = 28,
  parameter ACC_W = 40
) (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire sample_i,
  input wire [71:0] volt_i,
  input wire [71:0] cur_i,
  input wire [71:0] fvolt_i,
  input wire [71:0] fcur_i,
  input wire [`REA_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  output reg interrupt_line_zero_n_o
);

  // ==========================================================
  // Software registers
  reg [23:0] ofs_q [0:5];
  reg [7:0] thr_q;
  reg [1:0] sign_mode_q;
  reg [6:0] line_cycle_mode_q;
  reg [5:0] acc_mode_q;
  reg [12:0] mask_q;
  reg [12:0] status_q;
  reg [6:0] phase_sign_q;
  reg [31:0] nrg_q [0:5];

  wire wr_ofs;
  wire sign_monitor_select;
  wire clear_on_read_enable;
  wire [1:0] connection_select;
  assign sign_monitor_select = sign_mode_q[`REA_B_SIGN_SEL];
  assign clear_on_read_enable = line_cycle_mode_q[`REA_B_CLR_ON_RD];
  assign connection_select = acc_mode_q[`REA_B_CONNECTION_SELECT_LO+1:`REA_B_CONNECTION_SELECT_LO];
  assign wr_ofs = reg_wr_i && (reg_addr_i < `REA_A_OFS_BASE + 8'h06);

  // ==========================================================
  // Accumulation tick, fractional divider of the core clock
  reg [14:0] frac_q;
  reg tick_q;
  wire [15:0] frac_sum;
  wire [15:0] frac_rem;
  assign frac_sum = {1'b0, frac_q} + `REA_TICK_KHZ;
  assign frac_rem = frac_sum - `REA_CLK_KHZ;

  // Exact 1.024 MHz average rate; jitter of one core cycle is harmless
  // accumulate rate
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frac_q <= 15'h0000;
      tick_q <= 1'b0;
    end else if (frac_sum >= `REA_CLK_KHZ) begin
      frac_q <= frac_rem[14:0];
      tick_q <= 1'b1;
    end else begin
      frac_q <= frac_sum[14:0];
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // Threshold shared by all six accumulators
  wire signed [ACC_W-1:0] thr_pos;
  wire signed [ACC_W-1:0] thr_neg;
  assign thr_pos = {{(ACC_W-35){1'b0}}, thr_q, 27'h0000000};
  assign thr_neg = -thr_pos;

  // Channel 0..2 total A,B,C; 3..5 fundamental A,B,C
  wire [5:0] pulse;
  wire [5:0] neg;
  wire [5:0] half_evt;
  wire [5:0] nrg_rd;

  genvar ch;
  generate
    for (ch = 0; ch < 6; ch = ch + 1) begin : g_ch
      localparam P = ch % 3;
      wire [71:0] vbus;
      wire [71:0] ibus;
      wire signed [24:0] va;
      wire signed [24:0] vc;
      wire signed [24:0] vown;
      reg signed [24:0] vsel;
      wire signed [24:0] isel;
      wire signed [49:0] prod;
      wire signed [DW-1:0] ofs_ext;
      reg signed [DW-1:0] pwr_q;
      reg signed [ACC_W-1:0] acc_q;
      reg pulse_q;
      reg neg_q;
      wire signed [ACC_W-1:0] acc_sum;
      wire [31:0] step;
      wire [31:0] cnt_n;
      reg half_q;
      assign vbus = (ch < 3) ? volt_i : fvolt_i;
      assign ibus = (ch < 3) ? cur_i : fcur_i;
      assign va = {vbus[23], vbus[23:0]};
      assign vc = {vbus[71], vbus[71:48]};
      assign vown = {vbus[24*P+23], vbus[24*P+23:24*P]};
      assign isel = {ibus[24*P+23], ibus[24*P+23:24*P]};

      // Phase B voltage depends on the wiring of the service
      // B voltage swap
      always @* begin
        vsel = vown;
        if (P == 1) begin
          case (connection_select)
            2'b01: vsel = va - vc;
            2'b10: vsel = -va - vc;
            2'b11: vsel = -va;
            default: vsel = vown;
          endcase
        end
      end

      // Current is already shifted by 90 degrees, so the sign follows the load
      // sign convention
      assign prod = vsel * isel;
      assign ofs_ext = {{(DW-24){ofs_q[ch][23]}}, ofs_q[ch]};

      // Power refreshed on each 8 kHz sample; top bits dropped beyond full scale
      // offset before integration
      always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pwr_q <= {DW{1'b0}};
        end else if (sample_i) begin
          pwr_q <= prod[47:20] + ofs_ext;
        end
      end

      assign acc_sum = acc_q + {{(ACC_W-DW){pwr_q[DW-1]}}, pwr_q};

      // First stage: one pulse per tick at most, threshold removed
      // pulse and subtract
      always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          acc_q <= {ACC_W{1'b0}};
          pulse_q <= 1'b0;
          neg_q <= 1'b0;
        end else if (tick_q) begin
          if (acc_sum >= thr_pos) begin
            acc_q <= acc_sum - thr_pos;
            pulse_q <= 1'b1;
            neg_q <= 1'b0;
          end else if (acc_sum <= thr_neg) begin
            acc_q <= acc_sum + thr_pos;
            pulse_q <= 1'b1;
            neg_q <= 1'b1;
          end else begin
            acc_q <= acc_sum;
            pulse_q <= 1'b0;
          end
        end else begin
          pulse_q <= 1'b0;
        end
      end

      assign step = neg_q ? 32'hffffffff : 32'h00000001;
      assign cnt_n = nrg_q[ch] + step;
      wire nrg_rd_ch;
      assign nrg_rd_ch = reg_rd_i && (reg_addr_i == `REA_A_NRG_BASE + ch);
      assign nrg_rd[ch] = nrg_rd_ch;

      // Second stage counter, cleared by a read when enabled
      // pulse counting
      always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          nrg_q[ch] <= 32'h00000000;
          half_q <= 1'b0;
        end else begin
          half_q <= pulse_q && (cnt_n[30] != nrg_q[ch][30]);
          if (nrg_rd_ch && clear_on_read_enable) begin
            nrg_q[ch] <= pulse_q ? step : 32'h00000000;
          end else if (pulse_q) begin
            nrg_q[ch] <= cnt_n;
          end
        end
      end

      assign pulse[ch] = pulse_q;
      assign neg[ch] = neg_q;
      assign half_evt[ch] = half_q;
    end
  endgenerate

  // ==========================================================
  // Sign watch per phase on the selected power
  reg [2:0] last_neg_q;
  reg [2:0] rev_evt;
  reg [2:0] sel_pulse;
  reg [2:0] sel_neg;
  integer p;
  integer s;

  always @* begin
    sel_pulse = sign_monitor_select ? pulse[5:3] : pulse[2:0];
    sel_neg = sign_monitor_select ? neg[5:3] : neg[2:0];
    rev_evt = 3'b000;
    for (p = 0; p < 3; p = p + 1) begin
      rev_evt[p] = sel_pulse[p] && (sel_neg[p] != last_neg_q[p]);
    end
  end

  // Sign register and history move together with the flag
  // sign bits
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_neg_q <= 3'b000;
      phase_sign_q <= 7'h00;
    end else begin
      for (s = 0; s < 3; s = s + 1) begin
        if (sel_pulse[s]) begin
          last_neg_q[s] <= sel_neg[s];
        end
        if (rev_evt[s]) begin
          phase_sign_q[`REA_B_VSIGN_A+s] <= sel_neg[s];
        end
      end
    end
  end

  // ==========================================================
  // Status flags: a new event beats a clear in the same cycle
  wire [12:0] set_bits;
  wire [12:0] clr_bits;
  assign set_bits = {rev_evt, 6'h00, |half_evt[5:3], |half_evt[2:0], 2'b00};
  assign clr_bits = (reg_wr_i && reg_addr_i == `REA_A_INTERRUPT_STATUS_ZERO) ? reg_wdata_i[12:0] : 13'h0000;

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_q <= 13'h0000;
    end else begin
      status_q <= (status_q & ~clr_bits) | set_bits;
    end
  end

  // Line follows the flags one cycle later; stays low until every enabled flag is clear
  // sign and half-full interrupt
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_line_zero_n_o <= 1'b1;
    end else begin
      interrupt_line_zero_n_o <= ~|(status_q & mask_q & 13'h1c0c);
    end
  end

  // ==========================================================
  // Register writes
  integer k;
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (k = 0; k < 6; k = k + 1) begin
        ofs_q[k] <= 24'h000000;
      end
      thr_q <= `REA_THR_RST;
      sign_mode_q <= 2'b00;
      line_cycle_mode_q <= 7'h00;
      acc_mode_q <= 6'h00;
      mask_q <= 13'h0000;
    end else if (reg_wr_i) begin
      if (wr_ofs) begin
        ofs_q[reg_addr_i[2:0]] <= reg_wdata_i[23:0];
      end
      case (reg_addr_i)
        `REA_A_THR: thr_q <= reg_wdata_i[7:0];
        `REA_A_MEASUREMENT_MODE_REGISTER: sign_mode_q <= reg_wdata_i[1:0];
        `REA_A_LCYC: line_cycle_mode_q <= reg_wdata_i[6:0];
        `REA_A_ACCMODE: acc_mode_q <= reg_wdata_i[5:0];
        `REA_A_INTERRUPT_MASK_ZERO: mask_q <= reg_wdata_i[12:0];
        default: mask_q <= mask_q;
      endcase
    end
  end

  // ==========================================================
  // Register reads, one cycle after the strobe; unmapped reads give zero
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    if (reg_addr_i < `REA_A_OFS_BASE + 8'h06) begin
      rd_d = {8'h00, ofs_q[reg_addr_i[2:0]]};
    end else if (reg_addr_i >= `REA_A_NRG_BASE && reg_addr_i < `REA_A_NRG_BASE + 8'h06) begin
      rd_d = nrg_q[reg_addr_i[2:0]];
    end else begin
      case (reg_addr_i)
        `REA_A_THR: rd_d = {24'h000000, thr_q};
        `REA_A_MEASUREMENT_MODE_REGISTER: rd_d = {30'h00000000, sign_mode_q};
        `REA_A_LCYC: rd_d = {25'h0000000, line_cycle_mode_q};
        `REA_A_ACCMODE: rd_d = {26'h0000000, acc_mode_q};
        `REA_A_INTERRUPT_MASK_ZERO: rd_d = {19'h00000, mask_q};
        `REA_A_INTERRUPT_STATUS_ZERO: rd_d = {19'h00000, status_q};
        `REA_A_PHASE_SIGN_REGISTER: rd_d = {25'h0000000, phase_sign_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_d;
    end
  end

endmodule // rea_reactive_energy

// ### rea_reactive_energy_checker.sv
`include "rea_defs.vh"

// ==========================================================
// Port-level checker
module rea_reactive_energy_checker (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  input wire interrupt_line_zero_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] mask_q;
  reg clr_q;
  reg thr_wr_q;
  reg last_wv_q;
  reg [7:0] last_wa_q;
  reg [23:0] last_wd_q;

  // Shadow of writes, so readback is judged without peeking inside
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_q <= 32'h0;
      clr_q <= 1'b0;
      thr_wr_q <= 1'b0;
      last_wv_q <= 1'b0;
      last_wa_q <= 8'h00;
      last_wd_q <= 24'h0;
    end else if (reg_wr_i) begin
      last_wv_q <= 1'b1;
      last_wa_q <= reg_addr_i;
      last_wd_q <= reg_wdata_i[23:0];
      if (reg_addr_i == `REA_A_INTERRUPT_MASK_ZERO) mask_q <= reg_wdata_i;
      if (reg_addr_i == `REA_A_LCYC) clr_q <= reg_wdata_i[`REA_B_CLR_ON_RD];
      if (reg_addr_i == `REA_A_THR) thr_wr_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // Assertions
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_cfg_readback: assert property (reg_rd_i && !reg_wr_i && last_wv_q
    && reg_addr_i == last_wa_q && reg_addr_i <= `REA_A_THR |=> reg_rdata_o ==
    ((last_wa_q == `REA_A_THR) ? {24'h0, last_wd_q[7:0]} : {8'h00, last_wd_q}))
    else $error("config readback wrong");
  a_thr_reset: assert property (reg_rd_i && reg_addr_i == `REA_A_THR && !thr_wr_q
    |=> reg_rdata_o == {24'h0, `REA_THR_RST}) else $error("threshold reset wrong");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i >= 8'h0d
    && reg_addr_i <= 8'h0f |=> reg_rdata_o == 32'h0) else $error("unmapped read nonzero");
  a_status_fields: assert property (reg_rd_i && reg_addr_i == `REA_A_INTERRUPT_STATUS_ZERO
    |=> (reg_rdata_o & ~32'h00001c0c) == 32'h0) else $error("stray status bit");
  a_sign_fields: assert property (reg_rd_i && reg_addr_i == `REA_A_PHASE_SIGN_REGISTER
    |=> (reg_rdata_o & ~32'h00000070) == 32'h0) else $error("stray sign bit");
  a_irq_unmasked: assert property (((mask_q & 32'h00001c0c) == 32'h0) [*2]
    |-> interrupt_line_zero_n_o) else $error("interrupt low while masked");
  a_reset_idle: assert property ($rose(rst_b_i)
    |-> interrupt_line_zero_n_o && reg_rdata_o == 32'h0) else $error("bad reset outputs");
  a_read_clears: assert property ((reg_rd_i && clr_q && reg_addr_i >= `REA_A_NRG_BASE
    && reg_addr_i <= 8'h15) ##1 (reg_rd_i && $stable(reg_addr_i))
    |=> reg_rdata_o + 32'h1 <= 32'h2) else $error("read did not clear energy");

  // Main scenarios reached
  cover property (reg_rd_i && clr_q ##1 reg_rd_i);
  cover property ($fell(interrupt_line_zero_n_o));
  cover property ($rose(interrupt_line_zero_n_o));
endmodule // rea_reactive_energy_checker

bind rea_reactive_energy rea_reactive_energy_checker u_chk (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .interrupt_line_zero_n_o(interrupt_line_zero_n_o));

// ### test_reactive_energy_accumulator.sv
`include "rea_defs.vh"

module test_reactive_energy_accumulator;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [23:0] P = 24'h7fffff;
  localparam [23:0] N = 24'h800001;
  reg core_clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg sample_i = 1'b0;
  reg [71:0] volt_i = 72'h0;
  reg [71:0] cur_i = 72'h0;
  reg [71:0] fvolt_i = 72'h0;
  reg [71:0] fcur_i = 72'h0;
  reg [7:0] reg_addr_i = 8'h00;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [31:0] reg_wdata_i = 32'h0;
  wire [31:0] reg_rdata_o;
  wire irq_n;
  integer err_total = 0;
  integer n_checks = 0;
  integer seed = 20;
  integer i;
  reg [31:0] d;
  reg [63:0] nt;
  reg [63:0] note_q[$];
  reg pend_q = 1'b0;

  // 20 MHz core clock
  always #25 core_clk_i = ~core_clk_i;

  rea_reactive_energy dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sample_i(sample_i),
    .volt_i(volt_i), .cur_i(cur_i), .fvolt_i(fvolt_i), .fcur_i(fcur_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .interrupt_line_zero_n_o(irq_n));

  // ==========================================================
  // Helpers
  task chk(input [31:0] got, input [31:0] exp, input [31:0] msk);
    n_checks = n_checks + 1;
    if ((got & msk) !== (exp & msk)) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t got %h want %h mask %h", $time, got, exp, msk);
    end
  endtask

  // One register cycle; reads leave a note for the monitor
  task op(input w, input r, input [7:0] a, input [31:0] wd, input [31:0] e, input [31:0] m);
    @(negedge core_clk_i);
    reg_wr_i = w;
    reg_rd_i = r;
    reg_addr_i = a;
    reg_wdata_i = wd;
    if (r) note_q.push_back({e, m});
  endtask

  task wr(input [7:0] a, input [31:0] wd);
    op(1'b1, 1'b0, a, wd, 32'h0, 32'h0);
  endtask

  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    op(1'b0, 1'b1, a, 32'h0, e, m);
  endtask

  task nap(input integer n);
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (n) @(negedge core_clk_i);
  endtask

  // New sample on all phases, then let accumulation run
  task pwr(input [71:0] v, input [71:0] c, input [71:0] fv, input [71:0] fc, input integer n);
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    {volt_i, cur_i, fvolt_i, fcur_i} = {v, c, fv, fc};
    sample_i = 1'b1;
    @(negedge core_clk_i);
    sample_i = 1'b0;
    repeat (n) @(negedge core_clk_i);
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Read data lands one edge after the read is taken
  always @(posedge core_clk_i) begin
    if (pend_q) begin
      nt = note_q.pop_front();
      chk(reg_rdata_o, nt[63:32], nt[31:0]);
    end
    pend_q <= reg_rd_i;
  end

  // Watchdog, about two and a half times the expected run
  initial begin
    #1000000;
    err_total = err_total + 1;
    print_verdict;
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (2) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    rd(`REA_A_THR, 32'h3, ~32'h0);
    rd(`REA_A_PHASE_SIGN_REGISTER, 32'h0, ~32'h0);
    wr(`REA_A_NRG_BASE, 32'h5a5a5a5a);
    rd(`REA_A_NRG_BASE, 32'h0, ~32'h0);
    rd(8'h0d, 32'h0, ~32'h0);
    // Random top byte must not survive; offsets zeroed after
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      wr(i[7:0], d);
      rd(i[7:0], {8'h00, d[23:0]}, ~32'h0);
      wr(i[7:0], 32'h0);
    end
    wr(`REA_A_INTERRUPT_MASK_ZERO, 32'h1c0c);
    wr(`REA_A_LCYC, 32'h40);
    pwr({3{P}}, {3{P}}, 72'h0, 72'h0, 2000);
    chk({31'h0, irq_n}, 32'h1, 32'h1);
    rd(`REA_A_INTERRUPT_STATUS_ZERO, 32'h0, 32'h1c00);
    rd(`REA_A_NRG_BASE + 8'h03, 32'h0, ~32'h0);
    rd(`REA_A_NRG_BASE, 32'h0, 32'h80000000);
    rd(`REA_A_NRG_BASE, 32'h0, 32'hfffffffe);
    pwr({3{P}}, {3{N}}, 72'h0, 72'h0, 3000);
    chk({31'h0, irq_n}, 32'h0, 32'h1);
    rd(`REA_A_INTERRUPT_STATUS_ZERO, 32'h1c00, 32'h1c00);
    rd(`REA_A_PHASE_SIGN_REGISTER, 32'h70, 32'h70);
    pwr(72'h0, 72'h0, 72'h0, 72'h0, 10);
    // Negative steps cross bit 30 too, so half-full flags need clearing
    wr(`REA_A_INTERRUPT_STATUS_ZERO, 32'h1c0c);
    nap(3);
    chk({31'h0, irq_n}, 32'h1, 32'h1);
    rd(`REA_A_INTERRUPT_STATUS_ZERO, 32'h0, 32'h1c00);
    // History is negative: only the watched fundamental flips back to positive
    wr(`REA_A_MEASUREMENT_MODE_REGISTER, 32'h2);
    pwr({3{P}}, {3{N}}, {3{P}}, {3{P}}, 3000);
    rd(`REA_A_INTERRUPT_STATUS_ZERO, 32'h1c00, 32'h1c00);
    rd(`REA_A_PHASE_SIGN_REGISTER, 32'h00, 32'h70);
    // threshold never set below its default
    nap(2);
    print_verdict;
  end
endmodule // test_reactive_energy_accumulator
